// [design/dqs_regs.svh]
// Register indices, field positions, reset values for the I/O and scan block
`ifndef DQS_REGS_SVH
`define DQS_REGS_SVH

// Register indices; the APB byte address is four times the index
`define DQS_IDX_DAC 8'h00
`define DQS_IDX_DIO 8'h02
`define DQS_IDX_EXT 8'h04
`define DQS_IDX_CHAN 8'h06
`define DQS_IDX_GAIN 8'h08
`define DQS_IDX_MODE 8'h0A
`define DQS_IDX_SWTRIG 8'h0E
`define DQS_IDX_EXTCFG 8'h10
`define DQS_IDX_CONVCH 8'h14

// Trigger mode register fields
`define DQS_MODE_AUTO_SCAN_ENABLE 0
`define DQS_MODE_TPST 1
`define DQS_MODE_EITS 2
`define DQS_MODE_PTRG 3
`define DQS_MODE_W 4

// Field widths
`define DQS_GAIN_W 3
`define DQS_CHAN_W 8
`define DQS_NIB_W 4

// Reset values
`define DQS_RST_DAC 12'h000
`define DQS_RST_DOUT 16'h0000
`define DQS_RST_NIB 4'h0
`define DQS_RST_CHAN 8'h00
`define DQS_RST_GAIN 3'h0
`define DQS_RST_MODE 4'h0

`endif

// [design/dqs_pkg.sv]
// Types shared by the I/O and channel scan block
package dqs_pkg;

  // Extended output port pin modes; first one is the reset mode
  typedef enum logic [1:0] {
    DQS_EXT_INPUT,
    DQS_EXT_DRIVE,
    DQS_EXT_CHAN
  } dqs_ext_mode_e;

  // Edge detector state
  typedef struct packed {
    logic prev;
  } dqs_edge_s;

endpackage

// [design/dqs_edge_det.sv]
// Rising edge detector for one synchronous trigger level
`timescale 1ns/1ns
module dqs_edge_det (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Level in, one-cycle pulse out
  input wire logic level,
  output logic rise
);

  dqs_pkg::dqs_edge_s st_r;
  dqs_pkg::dqs_edge_s st_nxt;

  // Remember the last level
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = level;
  end

  // Low reset matches the idle level, so release gives no false edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Combinational pulse, registered by the owner
  assign rise = level & ~st_r.prev;

endmodule // dqs_edge_det

// [design/dqs_io_scan.sv]
// APB register bank: DAC code, digital I/O, extended port, channel scan
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "dqs_regs.svh"

////////////////////////////////////////////////////////////////////////////
// Operation
// - Written nibble reaches extended output pins only in drive mode.
// - Input mode: extended output pins released, port acts as input.
// - Channel mode: pins show upper channel nibble, scan on or off.
// - Write at 4h loads bits 3-0 into nibble; rest ignored.
// - Read at 4h: nibble in bits 7-4, extended inputs in 3-0.
// - Read at 2h returns the sixteen digital input levels.
// - Write at 2h updates the sixteen digital output latches.
// - Write at 0 holds a twelve-bit DAC code; upper bits ignored.
// - Scan off: the one selected channel is the register value.
// - Scan on: register value is the last channel, sequence starts at 0.
// - Scan on: each rising trigger advances the channel, wrapping to 0 after the last.
// - Channel register is 8 bits: low on-board, high board select.
// - One gain setting for all channels, unchanged by scanning.
// - Conversion starts on rising edge of the selected trigger.
// - Twelve-bit variant exposes converted channel number in data.
// - Channel register written at 6h; low nibble drives on-board mux with scan off.
// - Scan readback: end channel low, current channel high nibble.
module dqs_io_scan #(
  parameter int DAC_W = 12,
  parameter int DIO_W = 16,
  parameter int ADDR_W = 12,
  parameter bit CHAN_READBACK = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Digital I/O pins
  input wire logic [DIO_W-1:0] dig_in_bits,
  output logic [DIO_W-1:0] dig_out_bits,
  // Extended port pins
  input wire logic [3:0] ext_in_pins,
  output logic [3:0] ext_out_pins,
  output logic ext_out_oe_n,
  // Analog front end controls
  output logic [DAC_W-1:0] dac_code_bits,
  output logic [2:0] pga_gain,
  output logic [3:0] mux_onboard_sel,
  output logic [3:0] mux_board_sel,
  // Conversion triggers and start
  input wire logic pacer_tick,
  input wire logic ext_trig_n,
  output logic adc_start,
  output logic [3:0] conv_chan
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter checks

  if (DAC_W < 1 || DAC_W > 16) begin : g_bad_dac
    $error("DAC_W must lie in 1..16");
  end
  if (DIO_W < 1 || DIO_W > 32) begin : g_bad_dio
    $error("DIO_W must lie in 1..32");
  end
  // Word index needs bits 9:2 and the window check bits above 9
  if (ADDR_W < 11) begin : g_bad_addr
    $error("ADDR_W must be at least 11");
  end

  ////////////////////////////////////////////////////////////////////////
  // State

  // One packed record holds every flop of the bank outside the two edge
  // detectors; the next-state copy is built in a single process so no field has two drivers
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [DAC_W-1:0] dac;
    logic [DIO_W-1:0] dout;
    logic [3:0] ext_nib;
    logic [7:0] chan;
    logic [2:0] gain;
    logic [3:0] mode;
    dqs_pkg::dqs_ext_mode_e ext_mode;
    logic [3:0] scan_cur;
    logic sw_trig;
    logic adc_start;
    logic [3:0] conv_chan;
    logic [3:0] ext_out;
    logic ext_oe_n;
    logic [3:0] mux_sel;
    logic [3:0] board_sel;
  } dqs_state_s;

  dqs_state_s st_r;
  dqs_state_s st_nxt;

  // Trigger pulses and decode helpers
  logic pacer_rise;
  logic ext_rise;
  logic ext_trig_level;
  logic acc_wr;
  logic [7:0] word_idx;
  logic addr_ok;
  logic trig;
  logic scan_on;

  ////////////////////////////////////////////////////////////////////////
  // Trigger edge detectors

  // Both detectors run all the time, so a source switched in while its
  // level is already high does not fire until it falls and rises again
  // External trigger is active falling, so watch its inverse rise
  assign ext_trig_level = ~ext_trig_n;

  // Trigger levels are taken as synchronous to mclk
  dqs_edge_det u_pacer_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .level(pacer_tick),
    .rise(pacer_rise)
  );

  dqs_edge_det u_ext_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .level(ext_trig_level),
    .rise(ext_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Word map, byte address is four times the index:
  //   00 converter code, write only, reads zero
  //   08 digital inputs on read, output latches on write
  //   10 extended port: nibble on write, nibble and pins on read
  //   18 channel register; scan readback in the high nibble
  //   20 gain code, one setting shared by every channel
  //   28 trigger mode: pretrigger, external, pacer, scan
  //   38 software trigger, write data ignored
  //   40 extended port mode
  //   50 channel of the last started conversion
  // Any other word or a misaligned address answers with pslverr.
  // The window is 1 KB; address bits above it must be zero.

  // Write lands only at the access edge where pready is seen high
  assign acc_wr = psel & penable & pwrite & st_r.pready;
  assign word_idx = paddr[9:2];
  // Misaligned or out-of-window addresses count as unmapped
  assign addr_ok = (paddr[1:0] == 2'b00) &&
                   (paddr[ADDR_W-1:10] == '0);

  // Source select: external wins over internal sources
  always_comb begin
    if (st_r.mode[`DQS_MODE_EITS]) begin
      trig = ext_rise;
    end else if (st_r.mode[`DQS_MODE_TPST]) begin
      trig = pacer_rise;
    end else begin
      trig = st_r.sw_trig;
    end
  end

  assign scan_on = st_r.mode[`DQS_MODE_AUTO_SCAN_ENABLE];

  ////////////////////////////////////////////////////////////////////////
  // Next state

  // Timing from the setup cycle c0: pready, read data and pslverr
  // stand in c1 only. A write lands at the end of c1, and pins, mux
  // selects and extended drivers show it in c2.
  // A trigger edge seen in cycle k raises adc_start in cycle k+1.
  // The software trigger takes one more cycle through its own flop,
  // so its start comes in c3 after the write setup.
  always_comb begin
    st_nxt = st_r;
    st_nxt.sw_trig = 1'b0;
    st_nxt.adc_start = 1'b0;

    // Registered pready: one wait-free access cycle after setup
    st_nxt.pready = psel & ~penable;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;

    // Read data and error prepared in the setup cycle
    // so prdata is a flop that stands for the whole access cycle
    if (psel && !penable) begin
      if (!addr_ok) begin
        st_nxt.pslverr = 1'b1;
      end else if (word_idx == `DQS_IDX_DAC) begin
        st_nxt.prdata = 32'h0000_0000;
      end else if (word_idx == `DQS_IDX_DIO) begin
        st_nxt.prdata[DIO_W-1:0] = dig_in_bits;
      end else if (word_idx == `DQS_IDX_EXT) begin
        st_nxt.prdata[7:0] = {st_r.ext_nib, ext_in_pins};
      end else if (word_idx == `DQS_IDX_CHAN) begin
        // Scan off shows zeros in the high nibble
        if (scan_on) begin
          st_nxt.prdata[7:0] = {st_r.scan_cur, st_r.chan[3:0]};
        end else begin
          st_nxt.prdata[7:0] = {4'h0, st_r.chan[3:0]};
        end
      end else if (word_idx == `DQS_IDX_GAIN) begin
        st_nxt.prdata[2:0] = st_r.gain;
      end else if (word_idx == `DQS_IDX_MODE) begin
        st_nxt.prdata[3:0] = st_r.mode;
      end else if (word_idx == `DQS_IDX_SWTRIG) begin
        st_nxt.prdata = 32'h0000_0000;
      end else if (word_idx == `DQS_IDX_EXTCFG) begin
        st_nxt.prdata[1:0] = st_r.ext_mode;
      end else if (word_idx == `DQS_IDX_CONVCH) begin
        // High-resolution variant reads zero here
        if (CHAN_READBACK) begin
          st_nxt.prdata[3:0] = st_r.conv_chan;
        end
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end

    // Register writes
    // Refused or read-only words fall through, so a stray access
    // can never move a pin
    if (acc_wr && addr_ok) begin
      if (word_idx == `DQS_IDX_DAC) begin
        st_nxt.dac = pwdata[DAC_W-1:0];
      end else if (word_idx == `DQS_IDX_DIO) begin
        st_nxt.dout = pwdata[DIO_W-1:0];
      end else if (word_idx == `DQS_IDX_EXT) begin
        st_nxt.ext_nib = pwdata[3:0];
      end else if (word_idx == `DQS_IDX_CHAN) begin
        st_nxt.chan = pwdata[7:0];
      end else if (word_idx == `DQS_IDX_GAIN) begin
        st_nxt.gain = pwdata[2:0];
      end else if (word_idx == `DQS_IDX_MODE) begin
        st_nxt.mode = pwdata[3:0];
      end else if (word_idx == `DQS_IDX_SWTRIG) begin
        st_nxt.sw_trig = 1'b1;
      end else if (word_idx == `DQS_IDX_EXTCFG) begin
        // Unused code 3 falls back to input mode, the safe choice
        if (pwdata[1:0] == 2'h1) begin
          st_nxt.ext_mode = dqs_pkg::DQS_EXT_DRIVE;
        end else if (pwdata[1:0] == 2'h2) begin
          st_nxt.ext_mode = dqs_pkg::DQS_EXT_CHAN;
        end else begin
          st_nxt.ext_mode = dqs_pkg::DQS_EXT_INPUT;
        end
      end
    end

    // Conversion start and scan stepping
    // conv_chan records the channel converted now; scan_cur already
    // points at the next one, which the mux shows in the same cycle
    if (!scan_on) begin
      // Scan restarts from channel 0 whenever it is switched back on
      st_nxt.scan_cur = 4'h0;
      if (trig) begin
        st_nxt.adc_start = 1'b1;
        st_nxt.conv_chan = st_r.chan[3:0];
      end
    end else if (trig) begin
      st_nxt.adc_start = 1'b1;
      st_nxt.conv_chan = st_r.scan_cur;
      // Compare with >= so a lowered end channel cannot strand the count
      if (st_r.scan_cur >= st_r.chan[3:0]) begin
        st_nxt.scan_cur = 4'h0;
      end else begin
        st_nxt.scan_cur = st_r.scan_cur + 4'h1;
      end
    end

    // Mux select follows the next channel; gain never touched here
    // Board select is the raw register nibble, never the scan count
    if (st_nxt.mode[`DQS_MODE_AUTO_SCAN_ENABLE]) begin
      st_nxt.mux_sel = st_nxt.scan_cur;
    end else begin
      st_nxt.mux_sel = st_nxt.chan[3:0];
    end
    st_nxt.board_sel = st_nxt.chan[7:4];

    // Extended pin drivers
    // Taken from the next mode so the pins move with the write edge
    // Code 3 is stored as input mode, so it lands in the default
    case (st_nxt.ext_mode)
      dqs_pkg::DQS_EXT_DRIVE: begin
        st_nxt.ext_out = st_nxt.ext_nib;
        st_nxt.ext_oe_n = 1'b0;
      end
      dqs_pkg::DQS_EXT_CHAN: begin
        st_nxt.ext_out = st_nxt.chan[7:4];
        st_nxt.ext_oe_n = 1'b0;
      end
      default: begin
        st_nxt.ext_out = 4'h0;
        st_nxt.ext_oe_n = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Header values; the port mode starts input-only
      st_r <= '0;
      st_r.dac <= DAC_W'(`DQS_RST_DAC);
      st_r.dout <= DIO_W'(`DQS_RST_DOUT);
      st_r.ext_nib <= `DQS_RST_NIB;
      st_r.chan <= `DQS_RST_CHAN;
      st_r.gain <= `DQS_RST_GAIN;
      st_r.mode <= `DQS_RST_MODE;
      st_r.ext_mode <= dqs_pkg::DQS_EXT_INPUT;
      st_r.ext_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  // No output passes through logic, so nothing glitches on the pins

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign dig_out_bits = st_r.dout;
  assign ext_out_pins = st_r.ext_out;
  assign ext_out_oe_n = st_r.ext_oe_n;
  assign dac_code_bits = st_r.dac;
  assign pga_gain = st_r.gain;
  assign mux_onboard_sel = st_r.mux_sel;
  assign mux_board_sel = st_r.board_sel;
  assign adc_start = st_r.adc_start;
  assign conv_chan = st_r.conv_chan;

endmodule // dqs_io_scan

// [dv/dqs_io_scan_checker.sv]
// Port-level assertions for the I/O and channel scan block
`timescale 1ns/1ns
`include "dqs_regs.svh"
module dqs_io_scan_checker #(
  parameter int DAC_W = 12,
  parameter int DIO_W = 16,
  parameter int ADDR_W = 12
) (
  // Clock, reset, APB
  input wire logic mclk, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Pins
  input wire logic [DIO_W-1:0] dig_in_bits, dig_out_bits,
  input wire logic [3:0] ext_in_pins, ext_out_pins,
  input wire logic ext_out_oe_n, pacer_tick, ext_trig_n, adc_start,
  input wire logic [DAC_W-1:0] dac_code_bits,
  input wire logic [2:0] pga_gain,
  input wire logic [3:0] mux_onboard_sel, mux_board_sel, conv_chan
);
  logic wr_acc;
  // Write takes effect only at the completing edge
  assign wr_acc = psel && penable && pready && pwrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Handshake steps
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  ready_once_a: assert property (setup_s |=> access_s ##1 !pready)
    else $error("pready not one cycle after setup");
  bad_addr_a: assert property (psel && !penable && paddr[1:0] != 2'h0
    |=> pslverr && prdata == 32'h0) else $error("misaligned not refused");
  dac_load_a: assert property (
    wr_acc && paddr == {`DQS_IDX_DAC, 2'h0}
    |=> dac_code_bits == $past(pwdata[DAC_W-1:0])) else $error("dac code");
  dout_load_a: assert property (
    wr_acc && paddr == {`DQS_IDX_DIO, 2'h0}
    |=> dig_out_bits == $past(pwdata[DIO_W-1:0])) else $error("dig out");
  board_sel_a: assert property (
    wr_acc && paddr == {`DQS_IDX_CHAN, 2'h0}
    |-> ##2 mux_board_sel == $past(pwdata[7:4], 2)) else $error("board sel");
  // Scanning must never disturb the gain
  gain_hold_a: assert property (
    !(wr_acc && paddr == {`DQS_IDX_GAIN, 2'h0}) |=> $stable(pga_gain))
    else $error("gain moved without write");
  in_mode_a: assert property (ext_out_oe_n |-> ext_out_pins == 4'h0)
    else $error("released pins not zero");
  start_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("start longer than one cycle");
  conv_upd_a: assert property ($changed(conv_chan) |-> adc_start)
    else $error("channel moved without start");
endmodule // dqs_io_scan_checker

// [dv/dqs_host.sv]
// Host software model: APB master issuing one register transfer at a time
`timescale 1ns/1ns
module dqs_host (
  // Clock and answer
  input wire logic mclk,
  input wire logic pready,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  int hangs = 0;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Request held until pready is seen, then released
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) hangs++;
    psel <= 1'b0;
    penable <= 1'b0;
    // Stale data would hide a slave that samples late
    pwdata <= ~d;
  endtask
endmodule // dqs_host

// [dv/tb_dqs_io_scan.sv]
// Self-checking bench for the I/O and channel scan block
`timescale 1ns/1ns
`include "dqs_regs.svh"
module tb_dqs_io_scan;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic pacer_tick = 1'b0;
  logic ext_trig_n = 1'b1;
  logic [15:0] dig_in_bits = 16'h0000;
  logic [3:0] ext_in_pins = 4'h0;
  logic psel, penable, pwrite, pready, pslverr, ext_out_oe_n, adc_start;
  logic [11:0] paddr, dac_code_bits;
  logic [31:0] pwdata, prdata;
  logic [15:0] dig_out_bits;
  logic [3:0] ext_out_pins, mux_onboard_sel, mux_board_sel, conv_chan;
  logic [2:0] pga_gain;
  logic [32:0] exq[$];
  logic [15:0] rnd = 16'h879A;
  int fail_count = 0;
  int n_checks = 0;
  always #25 mclk = ~mclk;
  dqs_io_scan dqs_io_scan_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dig_in_bits(dig_in_bits), .dig_out_bits(dig_out_bits),
    .ext_in_pins(ext_in_pins), .ext_out_pins(ext_out_pins),
    .ext_out_oe_n(ext_out_oe_n), .dac_code_bits(dac_code_bits),
    .pga_gain(pga_gain), .mux_onboard_sel(mux_onboard_sel),
    .mux_board_sel(mux_board_sel), .pacer_tick(pacer_tick),
    .ext_trig_n(ext_trig_n), .adc_start(adc_start), .conv_chan(conv_chan));
  dqs_host dqs_host_i (.mclk(mclk), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [32:0] s, input logic [32:0] e,
                     input string what);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic stop_test();
    fail_count += dqs_host_i.hangs;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A hung transfer ends the run at once; stop_test counts it
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    dqs_host_i.xfer(w, a, d);
    if (dqs_host_i.hangs != 0) stop_test();
  endtask
  // Pins settle at the write edge; the task then waits two falling edges
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    bus(1'b1, {2'h0, i, 2'h0}, d);
    repeat (2) @(negedge mclk);
  endtask
  // Bit 32 of a note is the expected pslverr
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    exq.push_back({1'b0, e});
    bus(1'b0, {2'h0, i, 2'h0}, 32'h0);
  endtask
  task automatic wait_start();
    int n;
    for (n = 0; n < 10 && adc_start !== 1'b1; n++) @(negedge mclk);
    if (n == 10) begin
      fail_count++;
      stop_test();
    end
  endtask
  // Mux already shows the next scan channel while the start pulse stands
  task automatic pace(input logic [3:0] e, input logic [3:0] nx);
    @(posedge mclk);
    pacer_tick <= 1'b1;
    wait_start();
    chk(conv_chan, e, "scan channel");
    chk(mux_onboard_sel, nx, "scan mux");
    @(posedge mclk);
    pacer_tick <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // Read data against the oldest note
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite && exq.size() > 0)
      chk({pslverr, prdata}, exq.pop_front(), "read data");
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(ext_out_oe_n, 1'b1, "oe after reset");
    repeat (4) begin
      rnd = lfsr(rnd);
      @(posedge mclk);
      dig_in_bits <= ~rnd;
      ext_in_pins <= rnd[7:4];
      wr(`DQS_IDX_DIO, {16'hFFFF, rnd});
      chk(dig_out_bits, rnd, "digital out");
      rd(`DQS_IDX_DIO, {16'h0, ~rnd});
      wr(`DQS_IDX_DAC, {16'hFFFF, rnd});
      chk(dac_code_bits, rnd[11:0], "dac code");
      wr(`DQS_IDX_EXT, {16'hFFFF, rnd});
      rd(`DQS_IDX_EXT, {24'h0, rnd[3:0], rnd[7:4]});
    end
    wr(`DQS_IDX_EXTCFG, 32'h1);
    chk({ext_out_oe_n, ext_out_pins}, {1'b0, rnd[3:0]}, "drive");
    wr(`DQS_IDX_EXTCFG, 32'h0);
    chk({ext_out_oe_n, ext_out_pins}, 5'h10, "input mode");
    wr(`DQS_IDX_EXTCFG, 32'h2);
    wr(`DQS_IDX_CHAN, 32'h32);
    chk(mux_board_sel, 4'h3, "board select");
    wr(`DQS_IDX_GAIN, 32'h5);
    wr(`DQS_IDX_MODE, 32'h3);
    for (int i = 0; i < 5; i++) pace(4'(i % 3), 4'((i + 1) % 3));
    chk({pga_gain, ext_out_oe_n, ext_out_pins}, 8'hA3, "scan pins");
    rd(`DQS_IDX_CHAN, 32'h22);
    rd(`DQS_IDX_CONVCH, 32'h1);
    // External and pacer bits both set: the external source must win
    wr(`DQS_IDX_MODE, 32'hE);
    chk(mux_onboard_sel, 4'h2, "fixed channel");
    chk({ext_out_oe_n, ext_out_pins}, 5'h03, "pins, scan off");
    rd(`DQS_IDX_CHAN, 32'h02);
    rd(`DQS_IDX_MODE, 32'hE);
    rd(`DQS_IDX_GAIN, 32'h5);
    rd(`DQS_IDX_EXTCFG, 32'h2);
    @(posedge mclk);
    ext_trig_n <= 1'b0;
    wait_start();
    chk(conv_chan, 4'h2, "external start");
    @(posedge mclk);
    ext_trig_n <= 1'b1;
    wr(`DQS_IDX_MODE, 32'h0);
    wr(`DQS_IDX_CHAN, 32'h35);
    bus(1'b1, {2'h0, `DQS_IDX_SWTRIG, 2'h0}, 32'h0);
    wait_start();
    chk(conv_chan, 4'h5, "software start");
    // Unmapped and misaligned reads answer with an error and zero
    exq.push_back({1'b1, 32'h0});
    bus(1'b0, 12'h00C, 32'h0);
    exq.push_back({1'b1, 32'h0});
    bus(1'b0, 12'h011, 32'h0);
    // Misaligned write onto the output latch word must not land
    bus(1'b1, 12'h00A, 32'h0);
    repeat (2) @(negedge mclk);
    chk(dig_out_bits, rnd, "refused write");
    repeat (2) @(posedge mclk);
    stop_test();
  end
endmodule // tb_dqs_io_scan
bind dqs_io_scan dqs_io_scan_checker #(.DAC_W(DAC_W), .DIO_W(DIO_W),
  .ADDR_W(ADDR_W)) chk_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .dig_in_bits(dig_in_bits), .dig_out_bits(dig_out_bits),
  .ext_in_pins(ext_in_pins), .ext_out_pins(ext_out_pins),
  .ext_out_oe_n(ext_out_oe_n), .pacer_tick(pacer_tick),
  .ext_trig_n(ext_trig_n), .adc_start(adc_start),
  .dac_code_bits(dac_code_bits), .pga_gain(pga_gain),
  .mux_onboard_sel(mux_onboard_sel), .mux_board_sel(mux_board_sel),
  .conv_chan(conv_chan));
